// [mq_flags_pkg.sv]
// What this block does
// - Almost-full kept per queue, write-selected one shown
// - Offsets per queue, zero to depth, independent
// - Default programming gives offsets of 8 or 128
// - Write queue switch shows on second edge
// - Write reaching almost-full drops flag two cycles later
// - Read leaving almost-full raises flag within two cycles
// - Almost-full output changes only on clock edge
// - Reads update unselected queues' almost-full status
// - Per-queue flag buses copy almost-full and almost-empty
// - Almost-empty kept per queue, read-selected one shown
// - Read queue switch shows on second edge
// - Read reaching almost-empty drops flag two cycles later
// - Write leaving almost-empty raises flag within two cycles
// - Almost-empty output changes only on clock edge
// - Writes update unselected queues' almost-empty status
// - First write to shared queue drives valid low
// - Write into empty queue asserts valid within two cycles
// - Last enabled read deasserts valid on same edge
// - Default select low gives 8, high 128
package mq_flags_pkg;
  localparam int NUM_QUEUES = 8;
  localparam int QADDR_W = 3;
  localparam int LEVEL_W = 12;
  // Words per queue in the default configuration.
  localparam logic [11:0] QUEUE_DEPTH = 12'h800;
  localparam logic [11:0] OFFSET_LOW = 12'h008;
  localparam logic [11:0] OFFSET_HIGH = 12'h080;
  localparam logic [11:0] LEVEL_ONE = 12'h001;
  localparam logic [11:0] LEVEL_ZERO = 12'h000;
endpackage : mq_flags_pkg

// [queue_level.sv]
module queue_level
  import mq_flags_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_req,
  input wire logic rd_req,
  input wire logic [11:0] af_offset,
  input wire logic [11:0] ae_offset,
  output logic [11:0] level,
  output logic almost_full,
  output logic almost_empty,
  output logic empty
);
  logic [11:0] level_ff;
  logic [11:0] nxt_level;
  logic af_ff;
  logic nxt_af;
  logic ae_ff;
  logic nxt_ae;
  logic empty_ff;
  logic nxt_empty;
  logic wr_ok;
  logic rd_ok;

  // Occupancy moves on every accepted write or read, whether the other port selects the queue or not, so that
  // a queue's flags are already right when a port switches onto it.
  always_comb
  begin
    wr_ok = wr_req && (level_ff != QUEUE_DEPTH);
    rd_ok = rd_req && (level_ff != LEVEL_ZERO);
    nxt_level = level_ff;
    if (wr_ok && !rd_ok)
    begin
      nxt_level = level_ff + LEVEL_ONE;
    end
    else if (rd_ok && !wr_ok)
    begin
      nxt_level = level_ff - LEVEL_ONE;
    end
    if (rst)
    begin
      nxt_level = LEVEL_ZERO;
    end
    // Almost flags come from the registered level. That makes them the first of
    // two stages behind the edge that moved the level.
    nxt_af = (QUEUE_DEPTH - level_ff) <= af_offset;
    nxt_ae = level_ff <= ae_offset;
    // Empty turns on with the read that takes the last word, so valid cannot come
    // back one edge after it dropped. It turns off one edge late after a write.
    nxt_empty = (level_ff == LEVEL_ZERO) || (nxt_level == LEVEL_ZERO);
  end

  // Registers for the occupancy and the internal flag stage.
  always_ff @(posedge clk)
  begin
    level_ff <= nxt_level;
    af_ff <= nxt_af;
    ae_ff <= nxt_ae;
    empty_ff <= nxt_empty;
  end

  assign level = level_ff;
  assign almost_full = af_ff;
  assign almost_empty = ae_ff;
  assign empty = empty_ff;
endmodule : queue_level

// [multiqueue_almost_flags.sv]
module multiqueue_almost_flags
  import mq_flags_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [2:0] WRITE_QUEUE_ADDR,
  input wire logic WRITE_ADDR_ENABLE,
  input wire logic WRITE_EN,
  input wire logic [2:0] READ_QUEUE_ADDR,
  input wire logic READ_ADDR_ENABLE,
  input wire logic READ_EN,
  input wire logic DEFAULT_OFFSET_SELECT,
  input wire logic OFFSET_LOAD,
  input wire logic [2:0] OFFSET_QUEUE,
  input wire logic [11:0] AF_OFFSET,
  input wire logic [11:0] AE_OFFSET,
  output logic ACTIVE_ALMOST_FULL_N,
  output logic ACTIVE_ALMOST_EMPTY_N,
  output logic OUTPUT_VALID_N,
  output logic [7:0] ALMOST_FULL_BUS_N,
  output logic [7:0] ALMOST_EMPTY_BUS_N
);
  // One-hot decode of a queue address, shared by both ports and programming.
  function automatic logic [NUM_QUEUES-1:0] queue_onehot(input logic [QADDR_W-1:0] addr);
    logic [NUM_QUEUES-1:0] hot;
    hot = '0;
    hot[addr] = 1'b1;
    return hot;
  endfunction : queue_onehot

  // An offset above the depth is clamped, since the boundary must lie inside.
  function automatic logic [LEVEL_W-1:0] clamp_offset(input logic [LEVEL_W-1:0] value);
    logic [LEVEL_W-1:0] res;
    res = (value > QUEUE_DEPTH) ? QUEUE_DEPTH : value;
    return res;
  endfunction : clamp_offset

  logic df_meta_ff;
  logic df_sync_ff;
  logic [LEVEL_W-1:0] default_offset;
  logic [QADDR_W-1:0] wq_pend_ff;
  logic [QADDR_W-1:0] nxt_wq_pend;
  logic [QADDR_W-1:0] wq_sel_ff;
  logic [QADDR_W-1:0] nxt_wq_sel;
  logic [QADDR_W-1:0] rq_pend_ff;
  logic [QADDR_W-1:0] nxt_rq_pend;
  logic [QADDR_W-1:0] rq_sel_ff;
  logic [QADDR_W-1:0] nxt_rq_sel;
  logic [LEVEL_W-1:0] af_off_ff [NUM_QUEUES];
  logic [LEVEL_W-1:0] nxt_af_off [NUM_QUEUES];
  logic [LEVEL_W-1:0] ae_off_ff [NUM_QUEUES];
  logic [LEVEL_W-1:0] nxt_ae_off [NUM_QUEUES];
  logic [LEVEL_W-1:0] level [NUM_QUEUES];
  logic [NUM_QUEUES-1:0] q_af;
  logic [NUM_QUEUES-1:0] q_ae;
  logic [NUM_QUEUES-1:0] q_empty;
  logic [NUM_QUEUES-1:0] wr_hot;
  logic [NUM_QUEUES-1:0] rd_hot;
  logic [NUM_QUEUES-1:0] prog_hot;
  logic rd_fire;
  logic rd_last;
  logic paf_n_ff;
  logic nxt_paf_n;
  logic pae_n_ff;
  logic nxt_pae_n;
  logic ov_n_ff;
  logic nxt_ov_n;
  logic [NUM_QUEUES-1:0] af_bus_n_ff;
  logic [NUM_QUEUES-1:0] nxt_af_bus_n;
  logic [NUM_QUEUES-1:0] ae_bus_n_ff;
  logic [NUM_QUEUES-1:0] nxt_ae_bus_n;

  // The default-select strap is a pin, so it is synchronised before use.
  // Reset must be held for at least four edges so that the synchronised
  // level is settled when the defaults are taken and the flags follow them.
  always_ff @(posedge CLK)
  begin
    df_meta_ff <= DEFAULT_OFFSET_SELECT;
    df_sync_ff <= df_meta_ff;
  end

  assign default_offset = df_sync_ff ? OFFSET_HIGH : OFFSET_LOW;

  // Queue selection on both ports: the address is taken on an enabled edge,
  // moves to the active select one edge later, and the flag outputs register
  // that select's status on the edge after that.
  always_comb
  begin
    nxt_wq_pend = WRITE_ADDR_ENABLE ? WRITE_QUEUE_ADDR : wq_pend_ff;
    nxt_wq_sel = WRITE_ADDR_ENABLE ? wq_sel_ff : wq_pend_ff;
    nxt_rq_pend = READ_ADDR_ENABLE ? READ_QUEUE_ADDR : rq_pend_ff;
    nxt_rq_sel = READ_ADDR_ENABLE ? rq_sel_ff : rq_pend_ff;
    if (RST)
    begin
      nxt_wq_pend = '0;
      nxt_wq_sel = '0;
      nxt_rq_pend = '0;
      nxt_rq_sel = '0;
    end
  end

  always_ff @(posedge CLK)
  begin
    wq_pend_ff <= nxt_wq_pend;
    wq_sel_ff <= nxt_wq_sel;
    rq_pend_ff <= nxt_rq_pend;
    rq_sel_ff <= nxt_rq_sel;
  end

  // Offset programming replaces the serial port with a parallel load; reset
  // applies the default programming to every queue.
  always_comb
  begin
    prog_hot = OFFSET_LOAD ? queue_onehot(OFFSET_QUEUE) : '0;
    for (int q = 0; q < NUM_QUEUES; q++)
    begin
      nxt_af_off[q] = af_off_ff[q];
      nxt_ae_off[q] = ae_off_ff[q];
      if (RST)
      begin
        nxt_af_off[q] = default_offset;
        nxt_ae_off[q] = default_offset;
      end
      else if (prog_hot[q])
      begin
        nxt_af_off[q] = clamp_offset(AF_OFFSET);
        nxt_ae_off[q] = clamp_offset(AE_OFFSET);
      end
    end
  end

  always_ff @(posedge CLK)
  begin
    af_off_ff <= nxt_af_off;
    ae_off_ff <= nxt_ae_off;
  end

  // A read is only taken while the output register holds a valid word.
  assign rd_fire = READ_EN && !ov_n_ff;
  assign wr_hot = WRITE_EN ? queue_onehot(wq_sel_ff) : '0;
  assign rd_hot = rd_fire ? queue_onehot(rq_sel_ff) : '0;

  // One tracker per queue keeps occupancy and both internal flags, so reads
  // and writes move the status of queues that the other port does not show.
  for (genvar g = 0; g < NUM_QUEUES; g++)
  begin : gen_queue
    queue_level u_level (
      .clk(CLK),
      .rst(RST),
      .wr_req(wr_hot[g]),
      .rd_req(rd_hot[g]),
      .af_offset(af_off_ff[g]),
      .ae_offset(ae_off_ff[g]),
      .level(level[g]),
      .almost_full(q_af[g]),
      .almost_empty(q_ae[g]),
      .empty(q_empty[g])
    );
  end

  // The last word leaves when the read takes the only stored word and no
  // write refills that queue in the same cycle.
  assign rd_last = rd_fire && (level[rq_sel_ff] == LEVEL_ONE) &&
    !(WRITE_EN && (wq_sel_ff == rq_sel_ff));

  // Second flag stage: the selected queue's internal flag is registered onto
  // the active outputs, so a write or read boundary shows two edges later.
  // The trade is one cycle of latency for an output that is glitch free.
  always_comb
  begin
    nxt_paf_n = !q_af[wq_sel_ff];
    nxt_pae_n = !q_ae[rq_sel_ff];
    nxt_af_bus_n = ~q_af;
    nxt_ae_bus_n = ~q_ae;
    // Valid follows the selected queue's empty state, except that the read of
    // the last word clears it on that very edge.
    if (rd_last)
    begin
      nxt_ov_n = 1'b1;
    end
    else
    begin
      nxt_ov_n = q_empty[rq_sel_ff];
    end
    if (RST)
    begin
      nxt_paf_n = 1'b1;
      nxt_pae_n = 1'b0;
      nxt_ov_n = 1'b1;
      nxt_af_bus_n = '1;
      nxt_ae_bus_n = '0;
    end
  end

  // Output registers; every output is driven straight from one of these.
  always_ff @(posedge CLK)
  begin
    paf_n_ff <= nxt_paf_n;
    pae_n_ff <= nxt_pae_n;
    ov_n_ff <= nxt_ov_n;
    af_bus_n_ff <= nxt_af_bus_n;
    ae_bus_n_ff <= nxt_ae_bus_n;
  end

  assign ACTIVE_ALMOST_FULL_N = paf_n_ff;
  assign ACTIVE_ALMOST_EMPTY_N = pae_n_ff;
  assign OUTPUT_VALID_N = ov_n_ff;
  assign ALMOST_FULL_BUS_N = af_bus_n_ff;
  assign ALMOST_EMPTY_BUS_N = ae_bus_n_ff;
endmodule : multiqueue_almost_flags

// [mq_flags_chk.sv]
module mq_flags_chk
  import mq_flags_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [2:0] WRITE_QUEUE_ADDR,
  input wire logic WRITE_ADDR_ENABLE,
  input wire logic WRITE_EN,
  input wire logic [2:0] READ_QUEUE_ADDR,
  input wire logic READ_ADDR_ENABLE,
  input wire logic READ_EN,
  input wire logic ACTIVE_ALMOST_FULL_N,
  input wire logic ACTIVE_ALMOST_EMPTY_N,
  input wire logic OUTPUT_VALID_N,
  input wire logic [7:0] ALMOST_FULL_BUS_N,
  input wire logic [7:0] ALMOST_EMPTY_BUS_N
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] wq_ff, nxt_wq, rq_ff, nxt_rq;
  // Selections as seen on the pins, so that the flag buses can be indexed.
  always_comb
  begin
    nxt_wq = RST ? 3'h0 : WRITE_ADDR_ENABLE ? WRITE_QUEUE_ADDR : wq_ff;
    nxt_rq = RST ? 3'h0 : READ_ADDR_ENABLE ? READ_QUEUE_ADDR : rq_ff;
  end
  // Reset is folded into the next values, so this only registers them.
  always_ff @(posedge CLK)
  begin
    wq_ff <= nxt_wq;
    rq_ff <= nxt_rq;
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // No selection for two cycles, so the active flags already follow the tracked queue.
  sequence wr_quiet;
    !$past(WRITE_ADDR_ENABLE) && !$past(WRITE_ADDR_ENABLE, 2);
  endsequence
  sequence rd_quiet;
    !$past(READ_ADDR_ENABLE) && !$past(READ_ADDR_ENABLE, 2);
  endsequence
  af_copy_a: assert property (wr_quiet |->
    ACTIVE_ALMOST_FULL_N == ALMOST_FULL_BUS_N[wq_ff]) else $error("full flag off bus");
  ae_copy_a: assert property (rd_quiet |->
    ACTIVE_ALMOST_EMPTY_N == ALMOST_EMPTY_BUS_N[rq_ff]) else $error("empty flag off bus");
  af_fall_a: assert property ($fell(ACTIVE_ALMOST_FULL_N) |->
    $past(WRITE_EN, 3) || $past(WRITE_ADDR_ENABLE, 3)) else $error("full flag fell");
  af_rise_a: assert property ($rose(ACTIVE_ALMOST_FULL_N) |->
    $past(READ_EN, 3) || $past(WRITE_ADDR_ENABLE, 3)) else $error("full flag rose");
  ae_fall_a: assert property ($fell(ACTIVE_ALMOST_EMPTY_N) |->
    $past(READ_EN, 3) || $past(READ_ADDR_ENABLE, 3)) else $error("empty flag fell");
  ae_rise_a: assert property ($rose(ACTIVE_ALMOST_EMPTY_N) |->
    $past(WRITE_EN, 3) || $past(READ_ADDR_ENABLE, 3)) else $error("empty flag rose");
  valid_fall_a: assert property ($fell(OUTPUT_VALID_N) |->
    $past(WRITE_EN, 3) || $past(READ_ADDR_ENABLE, 3)) else $error("valid fell");
  // The last read raises valid on its own edge, so it is one sample back.
  valid_rise_a: assert property ($rose(OUTPUT_VALID_N) |->
    $past(READ_EN) || $past(READ_ADDR_ENABLE, 3)) else $error("valid rose");
endmodule : mq_flags_chk

bind multiqueue_almost_flags mq_flags_chk i_chk (.CLK, .RST, .WRITE_QUEUE_ADDR,
  .WRITE_ADDR_ENABLE, .WRITE_EN, .READ_QUEUE_ADDR, .READ_ADDR_ENABLE, .READ_EN,
  .ACTIVE_ALMOST_FULL_N, .ACTIVE_ALMOST_EMPTY_N, .OUTPUT_VALID_N, .ALMOST_FULL_BUS_N,
  .ALMOST_EMPTY_BUS_N);

// [mq_ctrl_model.sv]
module mq_ctrl_model
  import mq_flags_pkg::*;
(
  input wire logic clk,
  input wire logic valid_n,
  output logic [2:0] wr_q,
  output logic wr_sel,
  output logic wr_en,
  output logic [2:0] rd_q,
  output logic rd_sel,
  output logic rd_en
);
  timeunit 1ns;
  timeprecision 100ps;
  // The controller idles with every request low.
  initial
  begin
    {wr_q, wr_sel, wr_en, rd_q, rd_sel, rd_en} = 10'h000;
  end
  // One request per call, held over exactly one edge; calls are two cycles apart,
  // which keeps selections clear of each other.
  task automatic op(input int kind, input logic [2:0] q);
    @(posedge clk) #1;
    case (kind)
      0: wr_en = 1'b1;
      1: rd_en = !valid_n; // A read is only offered while a word is valid.
      2: {wr_q, wr_sel} = {q, 1'b1};
      default: {rd_q, rd_sel} = {q, 1'b1};
    endcase
    @(posedge clk) #1;
    {wr_sel, wr_en, rd_sel, rd_en} = 4'h0;
  endtask : op
endmodule : mq_ctrl_model

// [multiqueue_almost_flags_tb_top.sv]
module multiqueue_almost_flags_tb_top
  import mq_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK = 1'b0, RST = 1'b1, ld = 1'b0, df = 1'b0;
  logic [2:0] ld_q = 3'h0, wq, rq;
  logic [11:0] af_off = 12'h000, ae_off = 12'h000;
  logic ws, we, rs, re, paf_n, pae_n, ov_n;
  logic [7:0] af_bus_n, ae_bus_n;
  int failures = 0, check_count = 0;
  // Free-running 200 MHz clock.
  initial
  begin
    forever #2.5 CLK = ~CLK;
  end
  mq_ctrl_model i_ctrl (.clk(CLK), .valid_n(ov_n), .wr_q(wq), .wr_sel(ws), .wr_en(we),
    .rd_q(rq), .rd_sel(rs), .rd_en(re));
  multiqueue_almost_flags i_dut (.CLK(CLK), .RST(RST), .WRITE_QUEUE_ADDR(wq),
    .WRITE_ADDR_ENABLE(ws), .WRITE_EN(we), .READ_QUEUE_ADDR(rq), .READ_ADDR_ENABLE(rs),
    .READ_EN(re), .DEFAULT_OFFSET_SELECT(df), .OFFSET_LOAD(ld), .OFFSET_QUEUE(ld_q),
    .AF_OFFSET(af_off), .AE_OFFSET(ae_off), .ACTIVE_ALMOST_FULL_N(paf_n),
    .ACTIVE_ALMOST_EMPTY_N(pae_n), .OUTPUT_VALID_N(ov_n), .ALMOST_FULL_BUS_N(af_bus_n),
    .ALMOST_EMPTY_BUS_N(ae_bus_n));
  task automatic chk(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: saw %b, expected %b", $time, got, exp);
    end
  endtask : chk
  function automatic logic flag(input int sel);
    return sel == 0 ? paf_n : sel == 1 ? pae_n : ov_n;
  endfunction : flag
  // One request, then the chosen flag must hold for lat cycles and flip on the last.
  task automatic watch(input int kind, input logic [2:0] q, input int sel, input logic was,
    input int lat);
    i_ctrl.op(kind, q);
    for (int i = 0; i <= lat; i++)
    begin
      chk(flag(sel), i == lat ? !was : was);
      @(posedge CLK) #1;
    end
  endtask : watch
  task automatic load(input logic [2:0] q, input logic [11:0] af, input logic [11:0] ae);
    @(posedge CLK) #1;
    {ld_q, af_off, ae_off, ld} = {q, af, ae, 1'b1};
    @(posedge CLK) #1;
    ld = 1'b0;
  endtask : load
  task automatic check_reset();
    chk(paf_n, 1'b1);
    chk(pae_n, 1'b0);
    chk(ov_n, 1'b1);
    chk(&af_bus_n, 1'b1);
    chk(|ae_bus_n, 1'b0);
  endtask : check_reset
  // Queue 1 reaches almost empty at one word and almost full at three.
  task automatic fill_one();
    load(3'h1, 12'h7FD, 12'h001);
    load(3'h2, 12'h7F8, 12'h004);
    i_ctrl.op(2, 3'h1);
    i_ctrl.op(3, 3'h1);
    watch(0, 3'h0, 2, 1'b1, 2);
    watch(0, 3'h0, 1, 1'b0, 2);
    watch(0, 3'h0, 0, 1'b1, 2);
    chk(af_bus_n[1], 1'b0);
  endtask : fill_one
  // The read of the last word raises valid on its own edge and it stays up.
  task automatic drain_one();
    watch(1, 3'h0, 0, 1'b0, 2);
    watch(1, 3'h0, 1, 1'b1, 2);
    watch(1, 3'h0, 2, 1'b0, 0);
    chk(ov_n, 1'b1);
  endtask : drain_one
  // Queue 2 is filled while read selects queue 1, then read while write selects queue 1.
  task automatic cross_queues();
    i_ctrl.op(2, 3'h2);
    repeat (4) i_ctrl.op(0, 3'h0);
    repeat (3) @(posedge CLK) #1;
    chk(ae_bus_n[2], 1'b0);
    repeat (5) i_ctrl.op(0, 3'h0);
    repeat (3) @(posedge CLK) #1;
    chk(ae_bus_n[2], 1'b1);
    chk(paf_n, 1'b0);
    watch(3, 3'h2, 1, 1'b0, 2);
    watch(2, 3'h1, 0, 1'b0, 2);
    repeat (2) i_ctrl.op(1, 3'h0);
    repeat (3) @(posedge CLK) #1;
    chk(af_bus_n[2], 1'b1);
  endtask : cross_queues
  // Reset in mid-run with the strap at sel. Nine words in queue 0 then sit above
  // the low default offset and below the high one.
  task automatic default_offsets(input logic sel, input logic exp);
    @(posedge CLK) #1;
    {RST, df} = {1'b1, sel};
    repeat (6) @(posedge CLK) #1;
    RST = 1'b0;
    check_reset();
    repeat (9) i_ctrl.op(0, 3'h0);
    repeat (3) @(posedge CLK) #1;
    chk(pae_n, exp);
    chk(ov_n, 1'b0);
  endtask : default_offsets
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim
  // Main sequence after sixteen reset cycles.
  initial
  begin
    repeat (16) @(posedge CLK);
    #1 RST = 1'b0;
    check_reset();
    fill_one();
    drain_one();
    cross_queues();
    default_offsets(1'b0, 1'b1);
    default_offsets(1'b1, 1'b0);
    end_sim();
  end
  // A hang counts as a mismatch.
  initial
  begin
    repeat (4000) @(posedge CLK);
    failures++;
    end_sim();
  end
endmodule : multiqueue_almost_flags_tb_top
